//--- common/l1pw_map.svh
// address map, field positions and defaults of the level-one password block
`ifndef L1PW_MAP_SVH
`define L1PW_MAP_SVH

// table select values of the upper main-page window
`define L1PW_TBL_USER 8'h01
`define L1PW_TBL_LUT_A 8'h02
`define L1PW_TBL_LUT_B 8'h03
`define L1PW_TBL_CFG 8'h04
`define L1PW_TBL_MAIN 8'h05

// byte offsets
`define L1PW_ADDR_ID_HI 8'hc0
`define L1PW_ADDR_ID_LO 8'hc1
`define L1PW_ADDR_REV 8'hc2
`define L1PW_ADDR_GUARD_LO 8'hd0
`define L1PW_ADDR_WR_GUARD 8'hd1
`define L1PW_ADDR_RD_GUARD 8'hd2
`define L1PW_ADDR_SECRET_LO 8'hd3
`define L1PW_ADDR_SECRET_HI 8'hd6
`define L1PW_ADDR_ALARM_MASK 8'hf8
`define L1PW_ADDR_TOP 8'hff
`define L1PW_ADDR_USER_HI 8'hf7
`define L1PW_ADDR_CFG_HI 8'hc7
`define L1PW_ADDR_UPPER 8'h80
`define L1PW_ADDR_LOWER_HI 8'h7a
`define L1PW_ADDR_ENTRY_LO 8'h7b
`define L1PW_ADDR_ENTRY_HI 8'h7e

// bit positions of the guard bytes
`define L1PW_GB_MAIN_SEC 7
`define L1PW_GB_MAIN_MASK 6
`define L1PW_GB_CFG_LUT 5
`define L1PW_GB_USER_TOP 4
`define L1PW_GB_USER_BODY 3
`define L1PW_GB_LOWER 2
`define L1PW_GB_AUX_UP 1
`define L1PW_GB_AUX_LO 0

// shadow store: write guard, read guard, four secret bytes, alarm mask
`define L1PW_NV_BYTES 7
`define L1PW_NV_LAST 3'h6
`define L1PW_NV_WR_GUARD 3'h0
`define L1PW_NV_RD_GUARD 3'h1
`define L1PW_NV_SECRET 3'h2
`define L1PW_NV_ALARM 3'h6
`define L1PW_BYTE_ZERO 8'h00
`define L1PW_ENTRY_ZERO 32'h0000_0000

// identification, arbitrary neutral values
`define L1PW_CHIP_ID 16'h5a3c
`define L1PW_REVISION 8'h01

`endif

//--- common/l1pw_pkg.sv
// types shared by the level-one password block
package l1pw_pkg;

	// first alarm-mask byte, bit 7 down to bit 0
	typedef struct packed {
		logic temp_high_mask;
		logic temp_low_mask;
		logic supply_high_mask;
		logic supply_low_mask;
		logic monitor_one_high_mask;
		logic monitor_one_low_mask;
		logic monitor_two_high_mask;
		logic monitor_two_low_mask;
	} l1pw_alarm_mask_t;

	// working copies of the shadowed bytes, lowest address first
	typedef struct packed {
		logic [7:0] write_guard;
		logic [7:0] read_guard;
		logic [31:0] secret;
		l1pw_alarm_mask_t alarm_mask;
	} l1pw_shadow_t;

	// one byte access from the serial front end
	typedef struct packed {
		logic aux_sel;
		logic [7:0] table_sel;
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} l1pw_req_t;

	// restore sequencer, gray along fetch, copy, ready
	typedef enum logic [1:0] {
		L1PW_ST_FETCH = 2'b00,
		L1PW_ST_COPY = 2'b01,
		L1PW_ST_READY = 2'b11
	} l1pw_state_t;

endpackage

//--- hdl/l1pw_access_ctrl.sv
// level-one password access control, identification bytes and first alarm mask
// Contract
// - fixed sixteen-bit identifier at C0h and C1h
// - fixed revision byte at C2h
// - write guard byte, default zero, bit protects
// - write bits 7,6,5 guard their regions
// - write bits 4,3,2 guard their regions
// - write bits 1,0 guard auxiliary memory halves
// - read guard byte, default zero, bit protects
// - read bits 7,6,5 guard same regions
// - read bits 4,3,2 guard same regions
// - read bits 1,0 guard auxiliary halves
// - secret is 32 bits, MSB first, zero default
// - guarded regions need the password, others open
// - guard, secret, mask bytes persist, restored
// - alarm mask byte layout, zero default
// - mask bit lets alarm set masked flag
// - select bit chooses which mask set gates
`timescale 1ns/100ps
`include "l1pw_map.svh"

module l1pw_access_ctrl #(
	parameter logic [15:0] CHIP_ID = `L1PW_CHIP_ID,
	parameter logic [7:0] REVISION = `L1PW_REVISION
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire l1pw_pkg::l1pw_req_t req_i,
	output logic grant_o,
	output logic fwd_wr_o,
	output logic fwd_rd_o,
	output logic busy_o,
	output logic rvalid_o,
	output logic [7:0] rdata_o,
	input wire logic [7:0] alarm_flags_i,
	input wire logic [7:0] user_alarm_mask_i,
	input wire logic mask_select_i,
	output logic masked_interrupt_flag_o
);

	// which guard bit covers a byte
	function automatic logic [7:0] region_of(input logic aux, input logic [7:0] tbl, input logic [7:0] a);
		logic [7:0] r;
		logic up;
		r = `L1PW_BYTE_ZERO;
		up = (a >= `L1PW_ADDR_UPPER);
		if (aux) begin
			r[`L1PW_GB_AUX_UP] = up;
			r[`L1PW_GB_AUX_LO] = !up;
		end else if (!up) begin
			r[`L1PW_GB_LOWER] = (a <= `L1PW_ADDR_LOWER_HI);
		end else if (tbl == `L1PW_TBL_MAIN) begin
			r[`L1PW_GB_MAIN_SEC] = (a >= `L1PW_ADDR_GUARD_LO) && (a <= `L1PW_ADDR_SECRET_HI);
			r[`L1PW_GB_MAIN_MASK] = (a >= `L1PW_ADDR_ALARM_MASK);
		end else if (tbl == `L1PW_TBL_CFG || tbl == `L1PW_TBL_LUT_A || tbl == `L1PW_TBL_LUT_B) begin
			r[`L1PW_GB_CFG_LUT] = (a <= `L1PW_ADDR_CFG_HI);
		end else if (tbl == `L1PW_TBL_USER) begin
			r[`L1PW_GB_USER_TOP] = (a >= `L1PW_ADDR_ALARM_MASK);
			r[`L1PW_GB_USER_BODY] = (a <= `L1PW_ADDR_USER_HI);
		end
		return r;
	endfunction

	// shadow byte index of an offset, valid only with the hit bit
	function automatic logic [3:0] nv_slot_of(input logic [7:0] a);
		logic [3:0] s;
		s = 4'h0;
		if (a == `L1PW_ADDR_WR_GUARD) begin
			s = {1'b1, `L1PW_NV_WR_GUARD};
		end else if (a == `L1PW_ADDR_RD_GUARD) begin
			s = {1'b1, `L1PW_NV_RD_GUARD};
		end else if (a >= `L1PW_ADDR_SECRET_LO && a <= `L1PW_ADDR_SECRET_HI) begin
			s = {1'b1, 3'(`L1PW_NV_SECRET + 3'(a - `L1PW_ADDR_SECRET_LO))};
		end else if (a == `L1PW_ADDR_ALARM_MASK) begin
			s = {1'b1, `L1PW_NV_ALARM};
		end
		return s;
	endfunction

	l1pw_pkg::l1pw_state_t state;
	l1pw_pkg::l1pw_state_t next_state;
	logic [2:0] restore_idx;
	logic [2:0] next_restore_idx;
	logic [0:`L1PW_NV_BYTES-1][7:0] work;
	logic [0:3][7:0] entry;
	logic [7:0] nv_rdata;
	l1pw_pkg::l1pw_shadow_t cur;
	logic ready;

	// request decode
	logic [7:0] region;
	logic main_upper;
	logic is_id;
	logic [3:0] nv_slot;
	logic is_nv;
	logic [2:0] nv_idx;
	logic is_entry;
	logic is_own;
	logic unlocked;
	logic wr_blocked;
	logic rd_blocked;
	logic wr_ok;
	logic rd_ok;
	logic nv_wr;
	logic entry_wr;
	logic copy_now;
	logic answer_rd;
	logic [7:0] own_rdata;
	logic [7:0] next_rdata;
	logic [7:0] sel_mask;

	assign cur = l1pw_pkg::l1pw_shadow_t'(work);
	assign ready = (state == l1pw_pkg::L1PW_ST_READY);
	assign busy_o = !ready;
	assign region = region_of(req_i.aux_sel, req_i.table_sel, req_i.addr);
	assign main_upper = !req_i.aux_sel && (req_i.addr >= `L1PW_ADDR_UPPER) && (req_i.table_sel == `L1PW_TBL_MAIN);
	assign is_id = main_upper && (req_i.addr >= `L1PW_ADDR_ID_HI) && (req_i.addr <= `L1PW_ADDR_REV);
	assign nv_slot = nv_slot_of(req_i.addr);
	assign is_nv = main_upper && nv_slot[3];
	assign nv_idx = nv_slot[2:0];
	assign is_entry = !req_i.aux_sel && (req_i.addr >= `L1PW_ADDR_ENTRY_LO) && (req_i.addr <= `L1PW_ADDR_ENTRY_HI);
	assign is_own = is_id || is_nv || is_entry;

	// a zero secret with a zero entry already matches, as after the factory load
	assign unlocked = ({entry[0], entry[1], entry[2], entry[3]} == cur.secret);
	assign wr_blocked = |(region & cur.write_guard) && !unlocked;
	assign rd_blocked = |(region & cur.read_guard) && !unlocked;

	// grants; nothing is taken while the shadow copies are being restored
	assign wr_ok = ready && req_i.wr && !wr_blocked && !is_id;
	assign rd_ok = ready && req_i.rd && !rd_blocked;
	assign grant_o = wr_ok || rd_ok;
	assign fwd_wr_o = wr_ok && !is_own;
	assign fwd_rd_o = rd_ok && !is_own;
	assign nv_wr = wr_ok && is_nv;
	assign entry_wr = wr_ok && is_entry;
	assign copy_now = (state == l1pw_pkg::L1PW_ST_COPY);

	// read data of the bytes kept here; the entry reads as zero so it cannot leak
	assign own_rdata = (is_id && req_i.addr == `L1PW_ADDR_ID_HI) ? CHIP_ID[15:8] :
		(is_id && req_i.addr == `L1PW_ADDR_ID_LO) ? CHIP_ID[7:0] :
		is_id ? REVISION :
		is_nv ? work[nv_idx] : `L1PW_BYTE_ZERO;
	// a refused read is still answered here, with zero data
	assign answer_rd = ready && req_i.rd && (is_own || rd_blocked);
	assign next_rdata = rd_blocked ? `L1PW_BYTE_ZERO : own_rdata;

	// restore walk: fetch a byte, copy it, repeat up to the last
	always_comb begin
		next_state = state;
		next_restore_idx = restore_idx;
		case (state)
			l1pw_pkg::L1PW_ST_FETCH: begin
				next_state = l1pw_pkg::L1PW_ST_COPY;
			end
			l1pw_pkg::L1PW_ST_COPY: begin
				next_restore_idx = 3'(restore_idx + 3'h1);
				next_state = (restore_idx == `L1PW_NV_LAST) ? l1pw_pkg::L1PW_ST_READY : l1pw_pkg::L1PW_ST_FETCH;
			end
			default: begin
				next_state = l1pw_pkg::L1PW_ST_READY;
			end
		endcase
	end

	// sequencer state
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= l1pw_pkg::L1PW_ST_FETCH;
			restore_idx <= 3'h0;
		end else begin
			state <= next_state;
			restore_idx <= next_restore_idx;
		end
	end

	// working copies load from the store at power-up and follow host writes
	generate
		for (genvar k = 0; k < `L1PW_NV_BYTES; k++) begin : g_work
			always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					work[k] <= `L1PW_BYTE_ZERO;
				end else if (copy_now && restore_idx == 3'(k)) begin
					work[k] <= nv_rdata;
				end else if (nv_wr && nv_idx == 3'(k)) begin
					work[k] <= req_i.wdata;
				end
			end
		end
	endgenerate

	// entered password, volatile, most significant byte at the lowest offset
	generate
		for (genvar e = 0; e < 4; e++) begin : g_entry
			always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					entry[e] <= `L1PW_BYTE_ZERO;
				end else if (entry_wr && req_i.addr == 8'(`L1PW_ADDR_ENTRY_LO + 8'(e))) begin
					entry[e] <= req_i.wdata;
				end
			end
		end
	endgenerate

	// read answer register
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rvalid_o <= 1'b0;
			rdata_o <= `L1PW_BYTE_ZERO;
		end else begin
			rvalid_o <= answer_rd;
			if (answer_rd) begin
				rdata_o <= next_rdata;
			end
		end
	end

	// interrupt gating; the mask set in use is picked by the select bit
	assign sel_mask = mask_select_i ? user_alarm_mask_i : cur.alarm_mask;
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			masked_interrupt_flag_o <= 1'b0;
		end else begin
			masked_interrupt_flag_o <= |(alarm_flags_i & sel_mask);
		end
	end

	// shadow store; host writes go through to it so they survive power loss
	l1pw_nvm u_nvm (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.rd_addr_i(restore_idx),
		.rd_data_o(nv_rdata),
		.wr_en_i(nv_wr),
		.wr_addr_i(nv_idx),
		.wr_data_i(req_i.wdata)
	);

	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	property p_id_read;
		ready && req_i.rd && is_id && req_i.addr == `L1PW_ADDR_ID_HI |=> rvalid_o && rdata_o == CHIP_ID[15:8];
	endproperty
	a_id_read: assert property (p_id_read) else $error("identifier high byte wrong");

	property p_rev_read;
		ready && req_i.rd && is_id && req_i.addr == `L1PW_ADDR_REV |=> rvalid_o && rdata_o == REVISION;
	endproperty
	a_rev_read: assert property (p_rev_read) else $error("revision byte wrong");

	property p_id_write;
		req_i.wr && is_id && !req_i.rd |-> !grant_o;
	endproperty
	a_id_write: assert property (p_id_write) else $error("identifier write was granted");

	property p_wr_guarded;
		ready && req_i.wr && |(region & cur.write_guard) && !unlocked |-> !fwd_wr_o ##1 $stable(work);
	endproperty
	a_wr_guarded: assert property (p_wr_guarded) else $error("guarded write got through");

	property p_rd_guarded;
		ready && req_i.rd && |(region & cur.read_guard) && !unlocked |-> !fwd_rd_o ##1 (rvalid_o && rdata_o == 8'h00);
	endproperty
	a_rd_guarded: assert property (p_rd_guarded) else $error("guarded read returned data");

	property p_open_write;
		ready && req_i.wr && !is_id && (region & cur.write_guard) == 8'h00 |-> grant_o;
	endproperty
	a_open_write: assert property (p_open_write) else $error("unguarded write refused");

	property p_unlocked_write;
		ready && req_i.wr && unlocked && is_nv && nv_idx == `L1PW_NV_ALARM |=> work[`L1PW_NV_ALARM] == $past(req_i.wdata);
	endproperty
	a_unlocked_write: assert property (p_unlocked_write) else $error("unlocked mask write lost");

	// ready may only follow the copy of the last shadow byte, never a shortened walk
	property p_restore_bound;
		$fell(busy_o) |-> $past(copy_now) && $past(restore_idx) == `L1PW_NV_LAST;
	endproperty
	a_restore_bound: assert property (p_restore_bound) else $error("restore ended early");

	property p_ready_in_time;
		!ready |-> ##[1:14] ready;
	endproperty
	a_ready_in_time: assert property (p_ready_in_time) else $error("restore took too long");

	property p_masked_follow;
		|(alarm_flags_i & sel_mask) |=> masked_interrupt_flag_o;
	endproperty
	a_masked_follow: assert property (p_masked_follow) else $error("masked flag not raised");

	property p_masked_block;
		!mask_select_i && (alarm_flags_i & cur.alarm_mask) == 8'h00 |=> !masked_interrupt_flag_o;
	endproperty
	a_masked_block: assert property (p_masked_block) else $error("masked flag raised while blocked");

	c_restore_done: cover property ($rose(ready));
	c_unlocked_guarded: cover property (ready && req_i.wr && |(region & cur.write_guard) && unlocked);
	c_blocked_read: cover property (ready && req_i.rd && rd_blocked);
	c_masked_interrupt_flag_user: cover property (mask_select_i && |(alarm_flags_i & user_alarm_mask_i));

endmodule

//--- hdl/l1pw_nvm.sv
// nonvolatile shadow byte store with registered read port
`timescale 1ns/100ps
`include "l1pw_map.svh"

module l1pw_nvm (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic [2:0] rd_addr_i,
	output logic [7:0] rd_data_o,
	input wire logic wr_en_i,
	input wire logic [2:0] wr_addr_i,
	input wire logic [7:0] wr_data_i
);

	// the array has no reset so that it keeps its contents across resets
	logic [7:0] cells [0:`L1PW_NV_BYTES-1];

	// factory contents are all zero
	initial begin
		for (int i = 0; i < `L1PW_NV_BYTES; i++) begin
			cells[i] = `L1PW_BYTE_ZERO;
		end
	end

	// write port
	always_ff @(posedge sys_clk_i) begin
		if (wr_en_i) begin
			cells[wr_addr_i] <= wr_data_i;
		end
	end

	// read data from a register, one cycle after the address
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_o <= `L1PW_BYTE_ZERO;
		end else begin
			rd_data_o <= cells[rd_addr_i];
		end
	end

endmodule

//--- testbench/l1pw_host.sv
// host model issuing single byte requests to the access controller
`timescale 1ns/100ps

module l1pw_host (
	input wire logic sys_clk_i,
	output l1pw_pkg::l1pw_req_t req_o,
	input wire logic grant_i,
	input wire logic rvalid_i,
	input wire logic [7:0] rdata_i
);
	initial begin
		req_o = '0;
	end

	// request held for one cycle, answer taken at the edge that consumes it
	task automatic xfer(input logic aux, input logic [7:0] tbl, input logic [7:0] adr, input logic wr,
		input logic [7:0] dat, output logic g, output logic rv, output logic [7:0] rd);
		@(posedge sys_clk_i);
		#1;
		req_o = '{aux_sel: aux, table_sel: tbl, addr: adr, wr: wr, rd: !wr, wdata: dat};
		#20;
		g = grant_i;
		@(posedge sys_clk_i);
		#1;
		rv = rvalid_i;
		rd = rdata_i;
		// released lines flip so a stale byte never looks valid
		req_o.wr = 1'b0;
		req_o.rd = 1'b0;
		req_o.addr = ~adr;
		req_o.wdata = ~dat;
	endtask
endmodule

//--- testbench/tb.sv
// self-checking bench for the level-one password access controller
`timescale 1ns/100ps

module tb;
	localparam logic [15:0] ID = 16'h3c96; // arbitrary identifier
	localparam logic [7:0] REV = 8'h07; // arbitrary revision
	localparam logic [31:0] SECRET = 32'h1122_3344;
	logic sys_clk_i, reset_n_i, grant_o, fwd_wr_o, fwd_rd_o, busy_o, rvalid_o, flag_o, mask_select_i;
	logic [7:0] rdata_o, alarm_flags_i, user_alarm_mask_i;
	l1pw_pkg::l1pw_req_t req;
	int num_errors, check_count, cycles;
	logic g, rv;
	logic [7:0] rd;
	logic [1:0] fwd_seen;
	// one sample address per guard bit, index is the bit number
	logic [7:0] rtbl [8] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h04, 8'h05, 8'h05};
	logic [7:0] radr [8] = '{8'h7f, 8'h90, 8'h10, 8'h80, 8'hfc, 8'h90, 8'hfa, 8'hd0};

	l1pw_access_ctrl #(.CHIP_ID(ID), .REVISION(REV)) dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.req_i(req), .grant_o(grant_o), .fwd_wr_o(fwd_wr_o), .fwd_rd_o(fwd_rd_o), .busy_o(busy_o),
		.rvalid_o(rvalid_o), .rdata_o(rdata_o), .alarm_flags_i(alarm_flags_i),
		.user_alarm_mask_i(user_alarm_mask_i), .mask_select_i(mask_select_i),
		.masked_interrupt_flag_o(flag_o));

	l1pw_host host (.sys_clk_i(sys_clk_i), .req_o(req), .grant_i(grant_o), .rvalid_i(rvalid_o),
		.rdata_i(rdata_o));

	// forward strobes are combinational, so keep what they showed at the edge that took the request
	always @(posedge sys_clk_i) begin
		if (req.wr || req.rd) begin
			fwd_seen <= {fwd_wr_o, fwd_rd_o};
		end
	end

	// 20 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic wrb(input logic aux, input logic [7:0] tbl, input logic [7:0] adr, input logic [7:0] dat);
		host.xfer(aux, tbl, adr, 1'b1, dat, g, rv, rd);
	endtask

	task automatic rdb(input logic aux, input logic [7:0] tbl, input logic [7:0] adr);
		host.xfer(aux, tbl, adr, 1'b0, 8'h00, g, rv, rd);
	endtask

	// main-memory read, judged on grant and both forward strobes
	task automatic probe(input logic [7:0] tbl, input logic [7:0] adr, input logic [2:0] exp);
		rdb(1'b0, tbl, adr);
		check({g, fwd_seen}, exp);
	endtask

	// four bytes, most significant at the lowest offset
	task automatic put32(input logic [7:0] base, input logic [31:0] v);
		for (int k = 0; k < 4; k++) begin
			wrb(1'b0, 8'h05, 8'(base + k), v[31 - 8 * k -: 8]);
		end
	endtask

	// reset held three cycles, then wait out the restore under a bound
	task automatic do_reset;
		reset_n_i = 1'b0;
		repeat (3) @(posedge sys_clk_i);
		#1;
		check(busy_o, 1'b1);
		reset_n_i = 1'b1;
		// a request during the restore walk must be ignored
		rdb(1'b0, 8'h05, 8'hc0);
		check({g, rv}, 2'b00);
		for (int n = 0; n < 40 && busy_o !== 1'b0; n++) begin
			@(posedge sys_clk_i);
			#1;
		end
		check(busy_o, 1'b0);
	endtask

	task automatic test_id_defaults;
		logic [23:0] idb;
		idb = {ID, REV};
		for (int k = 0; k < 3; k++) begin
			rdb(1'b0, 8'h05, 8'(8'hc0 + k));
			check({rv, rd}, {1'b1, idb[23 - 8 * k -: 8]});
			wrb(1'b0, 8'h05, 8'(8'hc0 + k), 8'hff);
			check(g, 1'b0);
			rdb(1'b0, 8'h05, 8'(8'hc0 + k));
			check(rd, idb[23 - 8 * k -: 8]);
		end
		for (int k = 0; k < 7; k++) begin
			rdb(1'b0, 8'h05, (k < 6) ? 8'(8'hd1 + k) : 8'hf8);
			check({rv, rd}, 9'h100);
		end
	endtask

	// each guard bit locks its own region but not the next bit's region, and the right entry opens it
	task automatic test_guards;
		int j;
		put32(8'hd3, SECRET);
		for (int k = 0; k < 4; k++) begin
			rdb(1'b0, 8'h05, 8'(8'hd3 + k));
			check(rd, SECRET[31 - 8 * k -: 8]);
		end
		for (int i = 0; i < 8; i++) begin
			j = (i + 1) % 8;
			put32(8'h7b, SECRET);
			wrb(1'b0, 8'h05, 8'hd1, 8'(1 << i));
			wrb(1'b0, 8'h05, 8'hd2, 8'(1 << i));
			wrb(1'b0, 8'h05, 8'h7e, 8'h45);
			wrb(i < 2, rtbl[i], radr[i], 8'h5a);
			check({g, fwd_seen}, 3'b000);
			rdb(i < 2, rtbl[i], radr[i]);
			check({g, rv, rd}, 10'h100);
			wrb(j < 2, rtbl[j], radr[j], 8'h5a);
			check({g, fwd_seen}, 3'b110);
			rdb(j < 2, rtbl[j], radr[j]);
			check({g, fwd_seen}, 3'b101);
			wrb(1'b0, 8'h05, 8'h7e, 8'h44);
			wrb(i < 2, rtbl[i], radr[i], 8'h5a);
			check(g, 1'b1);
			rdb(i < 2, rtbl[i], radr[i]);
			check(g, 1'b1);
		end
		wrb(1'b0, 8'h05, 8'hd1, 8'h00);
		wrb(1'b0, 8'h05, 8'hd2, 8'h00);
	endtask

	// region end points, both lookup tables, the guard byte guarding itself, entry never leaks
	task automatic test_edges;
		wrb(1'b0, 8'h05, 8'hd2, 8'hff);
		wrb(1'b0, 8'h05, 8'h7e, 8'h45);
		probe(8'h02, 8'hc7, 3'b000);
		probe(8'h03, 8'h80, 3'b000);
		probe(8'h03, 8'hc8, 3'b101);
		probe(8'h05, 8'hcf, 3'b101);
		probe(8'h05, 8'hd7, 3'b101);
		probe(8'h05, 8'hd2, 3'b000);
		probe(8'h05, 8'hf7, 3'b101);
		probe(8'h01, 8'hf7, 3'b000);
		probe(8'h00, 8'h7a, 3'b000);
		probe(8'h00, 8'h7b, 3'b100);
		check({rv, rd}, 9'h100);
		wrb(1'b0, 8'h05, 8'h7e, 8'h44);
		wrb(1'b0, 8'h05, 8'hd2, 8'h00);
		check(g, 1'b1);
	endtask

	task automatic step_flag(input logic [7:0] fl, input logic sel, input logic [7:0] um, input logic exp);
		alarm_flags_i = fl;
		mask_select_i = sel;
		user_alarm_mask_i = um;
		@(posedge sys_clk_i);
		#1;
		check(flag_o, exp);
	endtask

	task automatic test_alarm;
		for (int i = 0; i < 8; i++) begin
			wrb(1'b0, 8'h05, 8'hf8, 8'(1 << i));
			step_flag(8'(1 << i), 1'b0, 8'h00, 1'b1);
			step_flag(~8'(1 << i), 1'b0, 8'hff, 1'b0);
		end
		step_flag(8'h01, 1'b1, 8'h01, 1'b1);
		step_flag(8'h80, 1'b1, 8'h01, 1'b0);
		step_flag(8'h80, 1'b0, 8'h00, 1'b1);
		step_flag(8'h00, 1'b0, 8'h00, 1'b0);
	endtask

	// shadowed bytes come back after reset, the volatile entry does not
	task automatic test_persist;
		wrb(1'b0, 8'h05, 8'hd1, 8'h02);
		do_reset();
		for (int k = 0; k < 4; k++) begin
			rdb(1'b0, 8'h05, 8'(8'hd3 + k));
			check(rd, SECRET[31 - 8 * k -: 8]);
		end
		rdb(1'b0, 8'h05, 8'hf8);
		check(rd, 8'h80);
		rdb(1'b0, 8'h05, 8'hd1);
		check(rd, 8'h02);
		wrb(1'b1, 8'h00, 8'h90, 8'h11);
		check(g, 1'b0);
	endtask

	// main sequence
	initial begin
		num_errors = 0;
		check_count = 0;
		cycles = 0;
		reset_n_i = 1'b0;
		alarm_flags_i = 8'h00;
		user_alarm_mask_i = 8'h00;
		mask_select_i = 1'b0;
		do_reset();
		test_id_defaults();
		test_guards();
		test_edges();
		test_alarm();
		test_persist();
		report_and_stop();
	end
endmodule
